// ===== include/btc_map.svh
// constant map for the bit-test, call and clear execution slice
`ifndef BTC_MAP_SVH
`define BTC_MAP_SVH
// ==========================================================
// register byte offsets on the wishbone side, and the file window in address bits 11:8
`define BTC_REG_CTRL 12'h000
`define BTC_REG_STATUS 12'h004
`define BTC_REG_PC 12'h008
`define BTC_REG_WORK 12'h00C
`define BTC_REG_WDOG 12'h010
`define BTC_REG_PAGE 12'h014
`define BTC_REG_STACK 12'h018
`define BTC_FILE_WIN 4'h1
// ==========================================================
// field positions and reset values
`define BTC_CTRL_RUN 0
`define BTC_CTRL_PSA 1
`define BTC_CTRL_RST 2'h0
`define BTC_ST_ZERO 0
`define BTC_ST_PDOWN 1
`define BTC_ST_TMOUT 2
`define BTC_PC_RST 12'h000
`define BTC_PAGE_RST 4'h0
// ==========================================================
// opcode patterns, matched on the upper bits or on all 13 bits of the word, and the prescaler top value
`define BTC_OPC_CALL 3'h4
`define BTC_OPC_FARCALL 3'h6
`define BTC_OPC_FJUMP 3'h7
`define BTC_OPC_SKCLR 4'h6
`define BTC_OPC_SKSET 4'h7
`define BTC_OPC_COMPL 6'h08
`define BTC_OPC_CLFILE 7'h01
`define BTC_OPC_CLWORK 13'h0001
`define BTC_OPC_WDCLR 13'h0004
`define BTC_PRESC_TOP 8'hFF
`endif

// ===== include/btc_pkg.sv
// types shared by the execution slice
package btc_pkg;
    // ==========================================================
    // decoded operation classes
    typedef enum logic [3:0] {
        OP_OTHER,
        OP_SKIP_CLR,
        OP_SKIP_SET,
        OP_CALL,
        OP_FAR_CALL,
        OP_FAR_JUMP,
        OP_CLR_WORK,
        OP_CLR_FILE,
        OP_WDOG_CLR,
        OP_COMPL
    } btc_op_t;
endpackage : btc_pkg

// ===== rtl/btc_file_regs.sv
// file register bank: one write port, two asynchronous read ports
`timescale 1ns/1ps
module btc_file_regs #(
    parameter int DEPTH = 64,
    parameter int WIDTH = 8,
    parameter int AW = 6
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic wrEn,
    input wire logic [AW-1:0] wrAddr,
    input wire logic [WIDTH-1:0] wrData,
    input wire logic [AW-1:0] rdAddrA,
    output logic [WIDTH-1:0] rdDataA,
    input wire logic [AW-1:0] rdAddrB,
    output logic [WIDTH-1:0] rdDataB
);
    logic [WIDTH-1:0] memQ [DEPTH];

    // ==========================================================
    // storage
    // flops rather than a ram so both readers see the word in the same cycle
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            for (int i = 0; i < DEPTH; i++) begin
                memQ[i] <= '0;
            end
        end else if (wrEn) begin
            memQ[wrAddr] <= wrData;
        end
    end

    // read ports
    assign rdDataA = memQ[rdAddrA];
    assign rdDataB = memQ[rdAddrB];
endmodule : btc_file_regs

// ===== rtl/btc_exec.sv
// execution slice: bit tests with skip, near and far calls, clears, complement
`timescale 1ns/1ps
`include "btc_map.svh"
module btc_exec import btc_pkg::*; #(
    parameter int STACK_DEPTH = 5,
    parameter int PC_W = 12
) (
    input wire logic clk,
    input wire logic sys_rst,
    output logic [PC_W-1:0] progAddr,
    input wire logic [12:0] progData,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [11:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o
);
    // ==========================================================
    // state
    logic [PC_W-1:0] pcQ, pcD;
    logic [12:0] instrQ, instrD;
    logic killQ, killD;
    logic killTailQ, killTailD;
    logic farPendQ, farPendD;
    logic farCallQ, farCallD;
    logic [7:0] workQ, workD;
    logic zeroQ, zeroD;
    logic tmoutQ, tmoutD;
    logic pdownQ, pdownD;
    logic [1:0] ctrlQ;
    logic [3:0] pageQ, pageD;
    logic [7:0] prescQ, prescD;
    logic [7:0] wdogQ, wdogD;
    logic [PC_W-1:0] stackQ [STACK_DEPTH];
    logic [2:0] spQ;
    logic ackQ;
    logic [31:0] datQ;

    // ==========================================================
    // decode
    function automatic btc_op_t btcDecode(input logic [12:0] w);
        btc_op_t r;
        r = OP_OTHER;
        if (w[12:10] == `BTC_OPC_CALL) r = OP_CALL;
        else if (w[12:10] == `BTC_OPC_FARCALL) r = OP_FAR_CALL;
        else if (w[12:10] == `BTC_OPC_FJUMP) r = OP_FAR_JUMP;
        else if (w[12:9] == `BTC_OPC_SKCLR) r = OP_SKIP_CLR;
        else if (w[12:9] == `BTC_OPC_SKSET) r = OP_SKIP_SET;
        else if (w[12:7] == `BTC_OPC_COMPL) r = OP_COMPL;
        else if (w[12:6] == `BTC_OPC_CLFILE) r = OP_CLR_FILE;
        else if (w == `BTC_OPC_CLWORK) r = OP_CLR_WORK;
        else if (w == `BTC_OPC_WDCLR) r = OP_WDOG_CLR;
        return r;
    endfunction : btcDecode

    btc_op_t op;
    logic runEn, live, isFar, testBit, destFile;
    logic skipTest, doCall, farDone, pushEn;
    logic clrWork, clrFile, wdogClr, compl;
    logic [7:0] fileRdA, fileRdB, complVal;
    logic [2:0] topIdx;
    logic [PC_W-1:0] stackTop;

    // the word in instrQ executes unless a skip or branch already killed it
    assign op = btcDecode(instrQ);
    assign runEn = ctrlQ[`BTC_CTRL_RUN];
    assign live = runEn & ~killQ & ~farPendQ;
    assign isFar = (op == OP_FAR_CALL) | (op == OP_FAR_JUMP);
    assign testBit = fileRdA[instrQ[8:6]];
    assign destFile = instrQ[6];
    assign complVal = ~fileRdA;

    // operation strobes, each valid for the single execute cycle
    assign skipTest = live & (((op == OP_SKIP_CLR) & ~testBit)
                    | ((op == OP_SKIP_SET) & testBit));
    assign doCall = live & (op == OP_CALL);
    assign farDone = runEn & ~killQ & farPendQ;
    assign pushEn = doCall | (farDone & farCallQ);
    assign clrWork = live & (op == OP_CLR_WORK);
    assign clrFile = live & (op == OP_CLR_FILE);
    assign wdogClr = live & (op == OP_WDOG_CLR);
    assign compl = live & (op == OP_COMPL);

    // ==========================================================
    // sequencing: prefetch, skip and branch
    // a skip only marks the prefetched word dead, so it costs the one extra
    // cycle of a no-op; a dead far word also kills its address word
    assign killD = runEn ? (skipTest | doCall | farDone
                 | (killQ & isFar & ~killTailQ)) : killQ;
    assign killTailD = runEn ? (killQ & isFar & ~killTailQ) : killTailQ;
    assign farPendD = runEn ? (live & isFar) : farPendQ;
    assign farCallD = runEn ? (live & (op == OP_FAR_CALL)) : farCallQ;
    assign instrD = runEn ? progData : instrQ;

    // pcQ already points past instrQ, so it is the return address
    assign pcD = ~runEn ? pcQ
               : farDone ? instrQ[PC_W-1:0]
               : doCall ? {pageQ[3:2], instrQ[9:0]}
               : PC_W'(pcQ + 1'b1);
    assign pageD = farDone ? {instrQ[11:10], pageQ[1:0]} : pageQ;

    // ==========================================================
    // data path: work register and zero flag
    // calls and bit tests never reach these terms, so flags hold
    assign workD = clrWork ? 8'h00
                 : (compl & ~destFile) ? complVal
                 : workQ;
    assign zeroD = (clrWork | clrFile) ? 1'b1
                 : compl ? (complVal == 8'h00)
                 : zeroQ;

    // core writes to the file bank
    logic coreWe;
    logic [7:0] coreWdata;
    assign coreWe = clrFile | (compl & destFile);
    assign coreWdata = clrFile ? 8'h00 : complVal;

    // ==========================================================
    // watchdog counter and prescaler
    // the prescaler keeps running for the timer but is only cleared when
    // it is assigned to the watchdog; otherwise the counter counts each cycle
    logic psaWdog, wdogTick;
    assign psaWdog = ctrlQ[`BTC_CTRL_PSA];
    assign wdogTick = ~psaWdog | (prescQ == `BTC_PRESC_TOP);
    assign prescD = (wdogClr & psaWdog) ? 8'h00 : 8'(prescQ + 1'b1);
    assign wdogD = wdogClr ? 8'h00 : wdogTick ? 8'(wdogQ + 1'b1) : wdogQ;

    // ==========================================================
    // wishbone slave
    logic wbReq, fileHit, wbStall, wbTake, wbWr, stWr;
    logic [31:0] regRd;
    assign wbReq = wb_cyc_i & wb_stb_i & ~ackQ;
    assign fileHit = wb_adr_i[11:8] == `BTC_FILE_WIN;
    // a core write to the file bank wins; the bus write waits for as long as coreWe is high
    assign wbStall = fileHit & wb_we_i & coreWe;
    assign wbTake = wbReq & ~wbStall;
    assign wbWr = wbTake & wb_we_i & wb_sel_i[0];
    assign stWr = wbWr & (wb_adr_i == `BTC_REG_STATUS);

    // write-one-to-clear on the timeout and power-down flags; the hardware set wins
    assign tmoutD = wdogClr | (tmoutQ & ~(stWr & wb_dat_i[`BTC_ST_TMOUT]));
    assign pdownD = wdogClr | (pdownQ & ~(stWr & wb_dat_i[`BTC_ST_PDOWN]));

    // unmapped offsets read as zero and still acknowledge
    assign regRd = fileHit ? 32'(fileRdB)
                 : (wb_adr_i == `BTC_REG_CTRL) ? 32'(ctrlQ)
                 : (wb_adr_i == `BTC_REG_STATUS) ? 32'({tmoutQ, pdownQ, zeroQ})
                 : (wb_adr_i == `BTC_REG_PC) ? 32'(pcQ)
                 : (wb_adr_i == `BTC_REG_WORK) ? 32'(workQ)
                 : (wb_adr_i == `BTC_REG_WDOG) ? 32'({prescQ, wdogQ})
                 : (wb_adr_i == `BTC_REG_PAGE) ? 32'(pageQ)
                 : (wb_adr_i == `BTC_REG_STACK) ? 32'(stackTop)
                 : 32'h0000_0000;

    // ==========================================================
    // file bank
    logic fileWe;
    logic [5:0] fileWaddr;
    logic [7:0] fileWdata;
    assign fileWe = coreWe | (wbWr & fileHit);
    assign fileWaddr = coreWe ? instrQ[5:0] : wb_adr_i[7:2];
    assign fileWdata = coreWe ? coreWdata : wb_dat_i[7:0];

    btc_file_regs #(.DEPTH(64), .WIDTH(8), .AW(6)) fileRegs (
        .clk(clk),
        .sys_rst(sys_rst),
        .wrEn(fileWe),
        .wrAddr(fileWaddr),
        .wrData(fileWdata),
        .rdAddrA(instrQ[5:0]),
        .rdDataA(fileRdA),
        .rdAddrB(wb_adr_i[7:2]),
        .rdDataB(fileRdB)
    );

    // ==========================================================
    // return stack: circular, oldest entry is overwritten on overflow
    assign topIdx = (spQ == 3'h0) ? 3'(STACK_DEPTH - 1) : 3'(spQ - 1'b1);
    assign stackTop = stackQ[topIdx];

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            spQ <= 3'h0;
            for (int i = 0; i < STACK_DEPTH; i++) begin
                stackQ[i] <= '0;
            end
        end else if (pushEn) begin
            stackQ[spQ] <= pcQ;
            spQ <= (spQ == 3'(STACK_DEPTH - 1)) ? 3'h0 : 3'(spQ + 1'b1);
        end
    end

    // ==========================================================
    // pipeline registers
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pcQ <= `BTC_PC_RST;
            instrQ <= 13'h0000;
            killQ <= 1'b0;
            killTailQ <= 1'b0;
            farPendQ <= 1'b0;
            farCallQ <= 1'b0;
            pageQ <= `BTC_PAGE_RST;
        end else begin
            pcQ <= pcD;
            instrQ <= instrD;
            killQ <= killD;
            killTailQ <= killTailD;
            farPendQ <= farPendD;
            farCallQ <= farCallD;
            pageQ <= (wbWr & (wb_adr_i == `BTC_REG_PAGE)) ? wb_dat_i[3:0] : pageD;
        end
    end

    // data and flag registers; timeout and power-down flags come up set as after power-on, the zero flag clear
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            workQ <= 8'h00;
            zeroQ <= 1'b0;
            tmoutQ <= 1'b1;
            pdownQ <= 1'b1;
            prescQ <= 8'h00;
            wdogQ <= 8'h00;
        end else begin
            workQ <= workD;
            zeroQ <= zeroD;
            tmoutQ <= tmoutD;
            pdownQ <= pdownD;
            prescQ <= prescD;
            wdogQ <= wdogD;
        end
    end

    // bus registers: ack one cycle after the strobe is taken, low again the next
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ctrlQ <= `BTC_CTRL_RST;
            ackQ <= 1'b0;
            datQ <= 32'h0000_0000;
        end else begin
            ackQ <= wbTake;
            if (wbTake & ~wb_we_i) datQ <= regRd;
            if (wbWr & (wb_adr_i == `BTC_REG_CTRL)) ctrlQ <= wb_dat_i[1:0];
        end
    end

    assign progAddr = pcQ;
    assign wb_ack_o = ackQ;
    assign wb_dat_o = datQ;

    // ==========================================================
    // assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    // call operands as plain signals so their past values can be taken
    logic [1:0] pageHi;
    logic [9:0] callImm;
    assign pageHi = pageQ[3:2];
    assign callImm = instrQ[9:0];

    skip_clear_a: assert property (live && op == OP_SKIP_CLR && !testBit |=> killQ)
        else $error("clear test did not skip");
    skip_set_a: assert property (live && op == OP_SKIP_SET && testBit
        |=> killQ ##1 (!killQ || killTailQ || !$past(runEn)))
        else $error("set test did not skip for one word");
    skip_nop_a: assert property (runEn && killQ |=> workQ == $past(workQ) && zeroQ == $past(zeroQ))
        else $error("discarded word changed state");
    far_skip_a: assert property (runEn && killQ && isFar && !killTailQ |=> killQ ##1 !farPendQ)
        else $error("far word skip not three cycles");
    call_push_a: assert property (doCall |=> stackTop == $past(pcQ))
        else $error("call return address wrong");
    call_target_a: assert property (doCall |=> pcQ == {$past(pageHi), $past(callImm)})
        else $error("call target wrong");
    call_flags_a: assert property (doCall |=> killQ && zeroQ == $past(zeroQ)
        && (tmoutQ == $past(tmoutQ) || $past(stWr)))
        else $error("call timing or flags wrong");
    clear_work_a: assert property (clrWork |=> workQ == 8'h00 && zeroQ)
        else $error("work clear failed");
    clear_file_a: assert property (clrFile |-> fileWe && fileWdata == 8'h00 ##1 zeroQ)
        else $error("file clear failed");
    wdog_clear_a: assert property (wdogClr |=> wdogQ == 8'h00 && (!$past(psaWdog) || prescQ == 8'h00))
        else $error("watchdog clear failed");
    presc_keep_a: assert property (wdogClr && !psaWdog |=> prescQ == 8'($past(prescQ) + 1'b1))
        else $error("prescaler cleared while on the timer");
    wdog_flags_a: assert property (wdogClr |=> tmoutQ && pdownQ)
        else $error("timeout or power-down flag not set");
    dest_work_a: assert property (compl && !destFile |=> workQ == ~$past(fileRdA))
        else $error("complement to work wrong");
    dest_file_a: assert property (compl && destFile |-> fileWe && fileWaddr == instrQ[5:0]
        && fileWdata == ~fileRdA ##1 zeroQ == ($past(fileRdA) == 8'hFF))
        else $error("complement to file wrong");

    skip_seen_c: cover property (skipTest ##1 killQ);
    far_skip_c: cover property (killQ && isFar ##1 killQ ##1 !killQ);
    call_seen_c: cover property (doCall ##2 live);
    wdog_seen_c: cover property (wdogClr && psaWdog);
endmodule : btc_exec

// ===== bench/testbench.sv
// self-checking bench for the bit-test, call and clear execution slice
`timescale 1ns/1ps
`include "btc_map.svh"
module testbench;
    // ==========================================================
    // clock, reset, program memory and bus signals
    logic clk;
    logic sys_rst;
    logic [11:0] progAddr;
    logic [12:0] progData;
    logic wbCyc;
    logic wbStb;
    logic wbWe;
    logic [11:0] wbAdr;
    logic [3:0] wbSel;
    logic [31:0] wbDatI;
    logic [31:0] wbDatO;
    logic wbAck;
    logic [12:0] rom [0:4095];
    logic [11:0] trace [$];
    logic tracing;
    int errCount;
    int checks;
    int cycleCount;

    // program words are answered in the same cycle, as the fetch expects
    assign progData = rom[progAddr];

    btc_exec #(.STACK_DEPTH(5), .PC_W(12)) uut (
        .clk(clk),
        .sys_rst(sys_rst),
        .progAddr(progAddr),
        .progData(progData),
        .wb_cyc_i(wbCyc),
        .wb_stb_i(wbStb),
        .wb_we_i(wbWe),
        .wb_adr_i(wbAdr),
        .wb_sel_i(wbSel),
        .wb_dat_i(wbDatI),
        .wb_dat_o(wbDatO),
        .wb_ack_o(wbAck)
    );

    // ==========================================================
    // clock and fetch trace; trace samples at the falling edge where the address is settled
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    always @(negedge clk) begin
        if (tracing) begin
            trace.push_back(progAddr);
        end
    end
    // hang guard: the whole run needs far fewer cycles than this
    always @(posedge clk) begin
        cycleCount++;
        if (cycleCount > 20000) begin
            errCount++;
            completeRun();
        end
    end

    // ==========================================================
    // shared tasks
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] expv);
        checks++;
        if (seen !== expv) begin
            errCount++;
            $display("MISMATCH %s expected %h seen %h", what, expv, seen);
        end
    endtask : check

    // classic single cycle; the request stands until ack is sampled high
    task automatic wbXfer(input logic we, input logic [11:0] adr, input logic [31:0] dat, input logic [3:0] sel,
                          output logic [31:0] rd);
        int n;
        n = 0;
        @(posedge clk);
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= we;
        wbAdr <= adr;
        wbDatI <= dat;
        wbSel <= sel;
        do begin
            @(posedge clk);
            n++;
        end while (wbAck !== 1'b1 && n < 50);
        if (n >= 50) begin
            check("bus ack", 32'h0000_0000, 32'h0000_0001);
        end
        rd = wbDatO;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        wbWe <= 1'b0;
    endtask : wbXfer

    task automatic wbWrite(input logic [11:0] adr, input logic [31:0] dat);
        logic [31:0] rd;
        wbXfer(1'b1, adr, dat, 4'h1, rd);
    endtask : wbWrite

    task automatic wbRead(input string what, input logic [11:0] adr, input logic [31:0] expv);
        logic [31:0] rd;
        wbXfer(1'b0, adr, 32'h0000_0000, 4'hF, rd);
        check(what, rd, expv);
    endtask : wbRead

    // fresh core with an all-nop program and an empty trace
    task automatic startScenario;
        for (int i = 0; i < 4096; i++) begin
            rom[i] = 13'h0000;
        end
        trace.delete();
        @(posedge clk);
        sys_rst <= 1'b1;
        repeat (16) @(posedge clk);
        sys_rst <= 1'b0;
    endtask : startScenario

    // let the core run a while, then halt it so results stay put for reading
    task automatic runProgram(input int cycles, input logic psa);
        tracing = 1'b1;
        wbWrite(`BTC_REG_CTRL, {30'h0, psa, 1'b1});
        repeat (cycles) @(posedge clk);
        wbWrite(`BTC_REG_CTRL, {30'h0, psa, 1'b0});
        tracing = 1'b0;
    endtask : runProgram

    // ==========================================================
    // scenarios
    task automatic scnBus;
        logic [31:0] rd;
        startScenario();
        wbRead("ctrl reset", `BTC_REG_CTRL, 32'h0000_0000);
        wbRead("status reset", `BTC_REG_STATUS, 32'h0000_0006);
        wbRead("pc reset", `BTC_REG_PC, 32'h0000_0000);
        wbRead("page reset", `BTC_REG_PAGE, 32'h0000_0000);
        wbRead("unmapped", 12'h0FC, 32'h0000_0000);
        wbWrite(`BTC_REG_PC, 32'h0000_0123);
        wbRead("pc read only", `BTC_REG_PC, 32'h0000_0000);
        wbWrite(12'h10C, 32'h0000_003C);
        wbXfer(1'b1, 12'h10C, 32'h0000_00C3, 4'h0, rd);
        wbRead("file sel gate", 12'h10C, 32'h0000_003C);
    endtask : scnBus

    // skip in both polarities, including over a two-word far call
    task automatic scnSkip;
        startScenario();
        wbWrite(12'h128, 32'h0000_005A);
        wbWrite(12'h12C, 32'h0000_0008);
        rom[0] = 13'h040A; // complement R10 into work
        rom[1] = 13'h0C8B; // bit 2 of R11 is clear: skip
        rom[2] = 13'h0001; // must be discarded
        rom[3] = 13'h0ECB; // bit 3 of R11 is set: skip
        rom[4] = 13'h1800; // far call, discarded
        rom[5] = 13'h0001; // its address word, discarded too
        rom[6] = 13'h0CCB; // bit 3 set: no skip
        rom[7] = 13'h044B; // complement R11 in place
        rom[8] = 13'h0ECB; // bit 3 now clear: no skip
        rom[9] = 13'h044A; // complement R10 in place
        runProgram(20, 1'b0);
        wbRead("work after skips", `BTC_REG_WORK, 32'h0000_00A5);
        wbRead("r11 complemented", 12'h12C, 32'h0000_00F7);
        wbRead("r10 complemented", 12'h128, 32'h0000_00A5);
        wbRead("zero flag clear", `BTC_REG_STATUS, 32'h0000_0006);
    endtask : scnSkip

    // near call with a non-zero page: push, target, two-cycle timing
    task automatic scnCall;
        int idx;
        idx = -1;
        startScenario();
        wbWrite(`BTC_REG_PAGE, 32'h0000_0008);
        rom[0] = 13'h1155;
        rom[1] = 13'h0001; // killed slot: would set the zero flag if run
        runProgram(8, 1'b0);
        for (int i = 0; i < trace.size(); i++) begin
            if (idx < 0 && trace[i] == 12'h001) begin
                idx = i;
            end
        end
        check("call seen", (idx >= 0 && idx + 2 < trace.size()), 32'h0000_0001);
        if (idx >= 0 && idx + 2 < trace.size()) begin
            check("call target", {20'h0, trace[idx + 1]}, 32'h0000_0955);
            check("after target", {20'h0, trace[idx + 2]}, 32'h0000_0956);
        end
        wbRead("stack top", `BTC_REG_STACK, 32'h0000_0001);
        wbRead("flags kept", `BTC_REG_STATUS, 32'h0000_0006);
    endtask : scnCall

    // skip over a far jump, then a far jump, a far call and a watchdog clear on the timer prescaler
    task automatic scnFar;
        int idx;
        logic [31:0] rd;
        idx = -1;
        startScenario();
        rom[0] = 13'h0C00; // bit 0 of R0 is clear: skip
        rom[1] = 13'h1C00; // far jump, discarded
        rom[2] = 13'h0001; // its address word, discarded too
        rom[3] = 13'h1C00; // far jump to 0xC20
        rom[4] = 13'h0C20;
        rom[5] = 13'h0001; // killed slot
        rom[12'hC20] = 13'h1800; // far call to 0x705
        rom[12'hC21] = 13'h0705;
        rom[12'hC22] = 13'h0001; // killed slot
        rom[12'h705] = 13'h0004; // watchdog clear, prescaler on the timer
        runProgram(16, 1'b0);
        for (int i = 0; i < trace.size(); i++) begin
            if (idx < 0 && trace[i] == 12'h001) begin
                idx = i;
            end
        end
        check("far seen", (idx >= 0 && idx + 8 < trace.size()), 32'h0000_0001);
        if (idx >= 0 && idx + 8 < trace.size()) begin
            check("far jump target", {20'h0, trace[idx + 5]}, 32'h0000_0C20);
            check("far call target", {20'h0, trace[idx + 8]}, 32'h0000_0705);
        end
        wbRead("far page", `BTC_REG_PAGE, 32'h0000_0004);
        wbRead("far return", `BTC_REG_STACK, 32'h0000_0C22);
        wbRead("far flags kept", `BTC_REG_STATUS, 32'h0000_0006);
        wbXfer(1'b0, `BTC_REG_WDOG, 32'h0000_0000, 4'hF, rd);
        // both count every cycle from reset, so only the watchdog clear separates them
        check("wdog restarted", (rd[7:0] < 8'h20), 32'h0000_0001);
        check("prescaler kept", (rd[15:8] == rd[7:0]), 32'h0000_0000);
    endtask : scnFar

    // clears of work, file register and watchdog with the prescaler on the watchdog
    task automatic scnClear;
        logic [31:0] rd;
        startScenario();
        wbWrite(12'h128, 32'h0000_005A);
        wbWrite(12'h11C, 32'h0000_00FF);
        wbWrite(`BTC_REG_STATUS, 32'h0000_0006);
        wbRead("flags cleared by bus", `BTC_REG_STATUS, 32'h0000_0000);
        repeat (100) @(posedge clk);
        rom[0] = 13'h040A;
        rom[1] = 13'h0001;
        rom[2] = 13'h0047;
        rom[3] = 13'h0004;
        runProgram(6, 1'b1);
        wbXfer(1'b0, `BTC_REG_WDOG, 32'h0000_0000, 4'hF, rd);
        // the prescaler restarts from zero, so only a few cycles of count remain
        check("watchdog cleared", {22'h0, rd[15:14], rd[7:0]}, 32'h0000_0000);
        wbRead("work cleared", `BTC_REG_WORK, 32'h0000_0000);
        wbRead("file cleared", 12'h11C, 32'h0000_0000);
        wbRead("flags set", `BTC_REG_STATUS, 32'h0000_0007);
        wbRead("ctrl kept", `BTC_REG_CTRL, 32'h0000_0002);
    endtask : scnClear

    // ==========================================================
    // verdict and main sequence
    task automatic completeRun;
        if (errCount == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : completeRun

    initial begin
        sys_rst = 1'b1;
        wbCyc = 1'b0;
        wbStb = 1'b0;
        wbWe = 1'b0;
        wbAdr = 12'h000;
        wbSel = 4'h0;
        wbDatI = 32'h0000_0000;
        tracing = 1'b0;
        errCount = 0;
        checks = 0;
        cycleCount = 0;
        for (int i = 0; i < 4096; i++) begin
            rom[i] = 13'h0000;
        end
        repeat (16) @(posedge clk);
        sys_rst <= 1'b0;
        scnBus();
        scnSkip();
        scnCall();
        scnFar();
        scnClear();
        completeRun();
    end
endmodule : testbench
